//--- verilog/bus_module_pkg.sv
// Shared constants and types for the backplane bus module.
// Assumes a single 10 MHz system clock; no software-visible registers.
package bus_module_pkg;

   // ------------------------------------------------------------
   // Clock and line-time-clock timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // 60 Hz period is 16 2/3 ms, held as 50/3 ms
   localparam int LTC60_MS_NUM = 50;
   localparam int LTC60_MS_DEN = 3;
   localparam int LTC50_MS = 20;
   localparam int LTC60_CYC = LTC60_MS_NUM * CYC_PER_MS / LTC60_MS_DEN;
   localparam int LTC50_CYC = LTC50_MS * CYC_PER_MS;

   // ------------------------------------------------------------
   // Bus widths and field positions
   // ------------------------------------------------------------
   localparam int DAL_W = 22;
   localparam int DATA_W = 16;
   localparam int PAGE_MSB = 12;
   localparam int LVL_MIN = 4;
   localparam int LVL_MAX = 7;
   localparam int LVL_N = 4;

   // ------------------------------------------------------------
   // Reset values and defaults (arbitrary, not from any part)
   // ------------------------------------------------------------
   localparam logic [12:0] DEF_BASE = 13'h1F40;
   localparam logic [15:0] DEF_VECTOR = 16'h00C0;
   localparam int DEF_LEVEL = 4;
   localparam int DEF_WORDS = 4;

   // Slave sequencer, Gray along idle -> address -> reply
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_REPLY = 2'b11
   } slave_st_t;

   // Incoming bus lines after inversion to active high
   typedef struct packed {
      logic sync;
      logic din;
      logic dout;
      logic wtbt;
      logic bs7;
      logic refr;
      logic init;
      logic iaki;
      logic dmgi;
      logic dcok;
      logic pok;
      logic [DAL_W-1:0] dal;
   } bus_in_t;

endpackage

//--- verilog/bus_sync.sv
// Two-stage synchroniser for a group of asynchronous lines.
// Assumes the group is sampled on the system clock only.
`timescale 1ns/1ps
`default_nettype none
module bus_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Lines
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   // First stage is read by the second stage only
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         meta_q <= '0;
         q_out <= '0;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- verilog/bus_ltc.sv
// Line time clock: periodic external event at 60 Hz or 50 Hz.
// Assumes enable and rate select come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bus_ltc
   import bus_module_pkg::*;
#(
   parameter int P60 = LTC60_CYC,
   parameter int P50 = LTC50_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Control
   input wire logic en_in,
   input wire logic sel50_in,
   // Event level, high during first half of each period
   output logic evnt_out
);
   localparam int CW = $clog2((P60 > P50) ? P60 : P50);
   localparam logic [CW-1:0] PER60 = CW'(P60);
   localparam logic [CW-1:0] PER50 = CW'(P50);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] per_w;

   if (P60 < 2 || P50 < 2) begin : g_bad_period
      $error("Line clock periods must be at least two cycles");
   end

   assign per_w = sel50_in ? PER50 : PER60;

   // One event per period; disabled clock holds the line released
   always_ff @(posedge clk_in) begin
      if (!rstn_in || !en_in) begin
         cnt_q <= '0;
         evnt_out <= 1'b0;
      end else begin
         cnt_q <= (cnt_q >= per_w - CW'(1)) ? '0 : cnt_q + CW'(1);
         evnt_out <= (cnt_q < (per_w >> 1));
      end
   end
endmodule
`default_nettype wire

//--- verilog/bus_module.sv
// Backplane bus module: slave word store, DMA request, interrupt and LTC.
// Assumes the board ties each *_OE_OUT to an open-drain low driver.
//
// How it works
// - Bus lines are true when low
// - Power-good lines are true when high
// - Mastership only granted outside processor cycles
// - On grant drop request, assert acknowledge
// - Pass grant on unless our request pending
// - Halt line stops processor while asserted
// - Refresh cycle read wakes all memories
// - Write data taken, slave replies
// - Reply only answers data in or out
// - Data in means read or vector fetch
// - Write/byte with data out means byte
// - Interrupt raised on one of four levels
// - Acknowledged requester drives its vector
// - Block acknowledge while request is stored
// - Bank 7 select marks upper 4K page
// - Initialize clears bus logic to initial state; word store and line clock keep theirs
// - Power-good lines show supplies fit
// - Line clock event every 16 2/3/20 ms
// - Low sixteen lines carry data too
`timescale 1ns/1ps
`default_nettype none
module bus_module
   import bus_module_pkg::*;
#(
   parameter logic [12:0] BASE = DEF_BASE,
   parameter logic [15:0] VECTOR = DEF_VECTOR,
   parameter int IRQ_LEVEL = DEF_LEVEL,
   parameter int WORDS = DEF_WORDS,
   parameter int LTC60_PERIOD = LTC60_CYC,
   parameter int LTC50_PERIOD = LTC50_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   // Bus control inputs, active low at the pins
   input wire logic BSYNC_L_IN,
   input wire logic BDIN_L_IN,
   input wire logic BDOUT_L_IN,
   input wire logic BWTBT_L_IN,
   input wire logic BBS7_L_IN,
   input wire logic BREF_L_IN,
   input wire logic BINIT_L_IN,
   input wire logic BIAKI_L_IN,
   input wire logic BDMGI_L_IN,
   // Power good, active high at the pins
   input wire logic BDCOK_H_IN,
   input wire logic BPOK_H_IN,
   // Data/address lines
   input wire logic [DAL_W-1:0] BDAL_L_IN,
   output logic [DATA_W-1:0] BDAL_L_OUT,
   output logic BDAL_OE_OUT,
   // Open-drain pull-downs, high pulls the line low
   output logic BRPLY_OE_OUT,
   output logic BDMR_OE_OUT,
   output logic BSACK_OE_OUT,
   output logic BHALT_OE_OUT,
   output logic BEVNT_OE_OUT,
   output logic [LVL_N-1:0] BIRQ_OE_OUT,
   // Daisy chain outputs, active low
   output logic BDMGO_L_OUT,
   output logic BIAKO_L_OUT,
   // User side
   input wire logic DMA_REQ_IN,
   input wire logic DMA_DONE_IN,
   input wire logic IRQ_REQ_IN,
   input wire logic HALT_REQ_IN,
   input wire logic LTC_EN_IN,
   input wire logic LINE_50HZ_IN,
   output logic DMA_MASTER_OUT,
   output logic REFRESH_OUT,
   output logic POWER_OK_OUT,
   output logic BUS_INIT_OUT
);
   localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;
   localparam logic [LVL_N-1:0] IRQ_BIT = LVL_N'(1) << (IRQ_LEVEL - LVL_MIN);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (IRQ_LEVEL < LVL_MIN || IRQ_LEVEL > LVL_MAX) begin : g_bad_level
      $error("IRQ_LEVEL must lie between 4 and 7");
   end
   if (WORDS < 2 || WORDS != (1 << IW) || IW > PAGE_MSB - 1) begin : g_bad_words
      $error("WORDS must be a power of two within the I/O page");
   end

   // Address match inside the upper 4K bank
   function automatic logic addr_hit(input logic [DAL_W-1:0] a, input logic bs7);
      addr_hit = bs7 && (a[PAGE_MSB:IW+1] == BASE[PAGE_MSB:IW+1]);
   endfunction

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   bus_in_t raw_w;
   bus_in_t b;

   // Inversion on the pin side keeps the first stage clean
   assign raw_w = '{sync: ~BSYNC_L_IN, din: ~BDIN_L_IN, dout: ~BDOUT_L_IN,
                   wtbt: ~BWTBT_L_IN, bs7: ~BBS7_L_IN, refr: ~BREF_L_IN,
                   init: ~BINIT_L_IN, iaki: ~BIAKI_L_IN, dmgi: ~BDMGI_L_IN,
                   dcok: BDCOK_H_IN, pok: BPOK_H_IN,
                   dal: ~BDAL_L_IN};

   bus_sync #(.W($bits(bus_in_t))) u_sync (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(raw_w),
      .q_out(b)
   );

   // ------------------------------------------------------------
   // State and decode
   // ------------------------------------------------------------
   slave_st_t st_q;
   logic [DAL_W-1:0] addr_q;
   logic hit_q;
   logic ref_q;
   logic rply_q;
   logic dal_oe_q;
   logic [DATA_W-1:0] dal_out_q;
   logic refresh_q;
   logic irq_pend_q;
   logic iack_q;
   logic iako_l_q;
   logic [LVL_N-1:0] birq_oe_q;
   logic dmr_q;
   logic sack_q;
   logic master_q;
   logic dmgo_l_q;
   logic bhalt_q;
   logic pwr_ok_q;
   logic init_q;
   logic [DATA_W-1:0] mem_q [WORDS];
   logic clr_w;
   logic rd_w;
   logic wr_w;
   logic ref_w;
   logic iack_w;
   logic [IW-1:0] idx_w;
   logic [DATA_W-1:0] rd_data_w;

   // Initialize or failing DC power puts the bus logic back to start; the word store and line clock are not touched
   assign clr_w = b.init || !b.dcok;
   assign idx_w = addr_q[IW:1];
   assign rd_data_w = mem_q[idx_w];
   // Data in with sync is a read; without sync it is a vector fetch
   assign ref_w = (st_q == ST_ADDR) && b.sync && b.din && ref_q;
   assign rd_w = (st_q == ST_ADDR) && b.sync && b.din && !ref_q && hit_q;
   assign wr_w = (st_q == ST_ADDR) && b.sync && !b.din && b.dout && hit_q;
   assign iack_w = (st_q == ST_IDLE) && !b.sync && b.din && b.iaki && irq_pend_q;

   // ------------------------------------------------------------
   // Slave sequencer
   // ------------------------------------------------------------
   // Reply stays up until the master drops its strobe
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN || clr_w) begin
         st_q <= ST_IDLE;
         addr_q <= '0;
         hit_q <= 1'b0;
         ref_q <= 1'b0;
         rply_q <= 1'b0;
         dal_oe_q <= 1'b0;
         // Held at pin level, so all ones leaves the lines released
         dal_out_q <= '1;
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= 1'b0;
         unique case (st_q)
            ST_IDLE: begin
               if (b.sync) begin
                  addr_q <= b.dal;
                  hit_q <= addr_hit(b.dal, b.bs7);
                  ref_q <= b.refr;
                  st_q <= ST_ADDR;
               end else if (iack_w) begin
                  dal_out_q <= ~VECTOR;
                  dal_oe_q <= 1'b1;
                  rply_q <= 1'b1;
                  st_q <= ST_REPLY;
               end
            end
            ST_ADDR: begin
               if (!b.sync) begin
                  st_q <= ST_IDLE;
               end else if (ref_w) begin
                  refresh_q <= 1'b1;
                  st_q <= ST_REPLY;
               end else if (rd_w) begin
                  dal_out_q <= ~rd_data_w;
                  dal_oe_q <= 1'b1;
                  rply_q <= 1'b1;
                  st_q <= ST_REPLY;
               end else if (wr_w) begin
                  rply_q <= 1'b1;
                  st_q <= ST_REPLY;
               end
            end
            ST_REPLY: begin
               if (!b.din && !b.dout) begin
                  rply_q <= 1'b0;
                  dal_oe_q <= 1'b0;
                  st_q <= b.sync ? ST_ADDR : ST_IDLE;
               end
            end
         endcase
      end
   end

   // Word store; byte lane picked by address bit 0
   always_ff @(posedge SYS_CLK_IN) begin
      if (wr_w && !clr_w) begin
         if (b.wtbt) begin
            if (addr_q[0]) begin
               mem_q[idx_w][15:8] <= b.dal[15:8];
            end else begin
               mem_q[idx_w][7:0] <= b.dal[7:0];
            end
         end else begin
            mem_q[idx_w] <= b.dal[DATA_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt request and acknowledge chain
   // ------------------------------------------------------------
   // A new request wins over the clear of the one being served
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN || clr_w) begin
         irq_pend_q <= 1'b0;
         iack_q <= 1'b0;
         iako_l_q <= 1'b1;
         birq_oe_q <= '0;
      end else begin
         if (IRQ_REQ_IN) begin
            irq_pend_q <= 1'b1;
         end else if (iack_w) begin
            irq_pend_q <= 1'b0;
         end
         // Hold the chain blocked until our acknowledge goes away
         if (iack_w) begin
            iack_q <= 1'b1;
         end else if (!b.iaki) begin
            iack_q <= 1'b0;
         end
         iako_l_q <= ~(b.iaki && !irq_pend_q && !iack_q);
         birq_oe_q <= (irq_pend_q && !iack_w) ? IRQ_BIT : '0;
      end
   end

   // ------------------------------------------------------------
   // DMA request, grant chain and acknowledge
   // ------------------------------------------------------------
   // Grant is taken only once the processor has left its cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN || clr_w) begin
         dmr_q <= 1'b0;
         sack_q <= 1'b0;
         master_q <= 1'b0;
         dmgo_l_q <= 1'b1;
      end else begin
         if (master_q) begin
            if (DMA_DONE_IN) begin
               master_q <= 1'b0;
               sack_q <= 1'b0;
            end
         end else if (dmr_q && b.dmgi && !b.sync) begin
            dmr_q <= 1'b0;
            sack_q <= 1'b1;
            master_q <= 1'b1;
         end else if (DMA_REQ_IN) begin
            dmr_q <= 1'b1;
         end
         dmgo_l_q <= ~(b.dmgi && !dmr_q && !master_q);
      end
   end

   // ------------------------------------------------------------
   // Halt, power and initialize status
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         bhalt_q <= 1'b0;
         pwr_ok_q <= 1'b0;
         init_q <= 1'b0;
      end else begin
         bhalt_q <= HALT_REQ_IN && !clr_w;
         pwr_ok_q <= b.dcok && b.pok;
         init_q <= b.init;
      end
   end

   // ------------------------------------------------------------
   // Line time clock
   // ------------------------------------------------------------
   bus_ltc #(.P60(LTC60_PERIOD), .P50(LTC50_PERIOD)) u_ltc (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .en_in(LTC_EN_IN),
      .sel50_in(LINE_50HZ_IN),
      .evnt_out(BEVNT_OE_OUT)
   );

   // ------------------------------------------------------------
   // Outputs, each straight from a flop
   // ------------------------------------------------------------
   assign BDAL_L_OUT = dal_out_q;
   assign BDAL_OE_OUT = dal_oe_q;
   assign BRPLY_OE_OUT = rply_q;
   assign BDMR_OE_OUT = dmr_q;
   assign BSACK_OE_OUT = sack_q;
   assign BHALT_OE_OUT = bhalt_q;
   assign BIRQ_OE_OUT = birq_oe_q;
   assign BDMGO_L_OUT = dmgo_l_q;
   assign BIAKO_L_OUT = iako_l_q;
   assign DMA_MASTER_OUT = master_q;
   assign REFRESH_OUT = refresh_q;
   assign POWER_OK_OUT = pwr_ok_q;
   assign BUS_INIT_OUT = init_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_write_seen;
      !clr_w && wr_w;
   endsequence
   sequence s_read_seen;
      !clr_w && rd_w;
   endsequence

   a_reply_cause: assert property (rply_q |-> $past(b.din || b.dout))
      else $error("Reply without data strobe");
   a_write_reply: assert property (s_write_seen |=> rply_q && !dal_oe_q)
      else $error("Write not answered");
   a_read_drive: assert property (s_read_seen |=>
      rply_q && dal_oe_q && dal_out_q == ~$past(rd_data_w))
      else $error("Read data not driven");
   a_vector_out: assert property ((!clr_w && iack_w) |=>
      dal_out_q == ~VECTOR && dal_oe_q && rply_q)
      else $error("Vector not driven");
   a_iako_block: assert property (!iako_l_q |->
      $past(b.iaki) && !$past(irq_pend_q) && !$past(iack_q))
      else $error("Acknowledge passed while holding request");
   a_grant_block: assert property (!dmgo_l_q |->
      $past(b.dmgi) && !$past(dmr_q) && !$past(master_q))
      else $error("Grant passed while requesting");
   a_sack_take: assert property ($rose(sack_q) |->
      !dmr_q && $past(dmr_q && b.dmgi && !b.sync))
      else $error("Acknowledge without grant");
   a_irq_level: assert property ((irq_pend_q && !clr_w && !iack_w) |=>
      birq_oe_q == IRQ_BIT)
      else $error("Request not on its level");
   a_refresh_quiet: assert property ((!clr_w && ref_w) |=>
      refresh_q && !rply_q ##1 !refresh_q)
      else $error("Refresh cycle mishandled");
   a_byte_lane: assert property ((s_write_seen ##0 b.wtbt && !addr_q[0]) |=>
      rd_data_w[15:8] == $past(rd_data_w[15:8]))
      else $error("Byte write touched high byte");
   a_init_clear: assert property (clr_w |=>
      st_q == ST_IDLE && !irq_pend_q && !sack_q && !dmr_q)
      else $error("Initialize did not clear");
   a_halt_follow: assert property ((!clr_w && HALT_REQ_IN) |=> bhalt_q)
      else $error("Halt not driven");
endmodule
`default_nettype wire

//--- sim/bus_host_model.sv
// Processor side of the backplane: slave cycles, vector fetch, DMA grant.
// Assumes the bench inverts b_out to pin levels; lines here are active high.
`timescale 1ns/1ps
`default_nettype none
module bus_host_model
   import bus_module_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Device answers
   input wire logic rply_in,
   input wire logic sack_in,
   input wire logic iako_l_in,
   input wire logic dmgo_l_in,
   input wire logic dal_oe_in,
   input wire logic [DATA_W-1:0] dal_l_in,
   // Processor lines active high; wired data/address lines at pin level
   output bus_in_t b_out,
   output logic [DAL_W-1:0] pin_dal_out
);
   bus_in_t b;
   int n;
   assign b_out = b;
   // Wired lines, terminated high when nobody drives
   assign pin_dal_out = ~b.dal & (dal_oe_in ? {6'h3F, dal_l_in} : {DAL_W{1'b1}});
   // Supplies good from power-up
   initial begin
      b = '0;
      b.dcok = 1'b1;
      b.pok = 1'b1;
   end
   // Bounded wait for the reply line
   task automatic wait_rply(input logic v);
      for (n = 0; n < 20 && rply_in !== v; n++) @(posedge clk_in);
   endtask
   // One slave cycle; a strobe holds until the reply is sampled
   task automatic xfer(input bit wr, input bit bs7, input bit refr, input bit bytew,
         input logic [DAL_W-1:0] a, input logic [DATA_W-1:0] wd,
         output logic [DATA_W-1:0] rd, output bit ok);
      @(posedge clk_in);
      b.dal <= a;
      b.bs7 <= bs7;
      b.refr <= refr;
      b.wtbt <= wr;
      repeat (3) @(posedge clk_in);
      b.sync <= 1'b1; // Address settled first
      repeat (3) @(posedge clk_in);
      b.bs7 <= 1'b0;
      b.wtbt <= wr & bytew;
      b.dal <= wr ? {6'h00, wd} : '0;
      repeat (3) @(posedge clk_in);
      b.din <= ~wr;
      b.dout <= wr;
      wait_rply(1'b1);
      ok = rply_in;
      rd = ~pin_dal_out[DATA_W-1:0];
      b.din <= 1'b0;
      b.dout <= 1'b0;
      wait_rply(1'b0);
      b.sync <= 1'b0;
      b.refr <= 1'b0;
      b.wtbt <= 1'b0;
      b.dal <= '0;
   endtask
   // Vector fetch: data in without sync, acknowledge held to the end
   task automatic iack(output logic [DATA_W-1:0] vec, output bit ok, output bit passed);
      passed = 1'b0;
      @(posedge clk_in);
      b.iaki <= 1'b1;
      b.din <= 1'b1;
      for (n = 0; n < 20 && rply_in !== 1'b1; n++) begin
         @(posedge clk_in);
         if (iako_l_in === 1'b0) passed = 1'b1;
      end
      ok = rply_in;
      vec = ~pin_dal_out[DATA_W-1:0];
      b.din <= 1'b0;
      wait_rply(1'b0);
      b.iaki <= 1'b0;
   endtask
   // Grant only between our own cycles
   task automatic grant(output bit ok, output bit passed);
      passed = 1'b0;
      @(posedge clk_in);
      b.dmgi <= 1'b1;
      for (n = 0; n < 20 && sack_in !== 1'b1; n++) begin
         @(posedge clk_in);
         if (dmgo_l_in === 1'b0) passed = 1'b1;
      end
      ok = sack_in;
      b.dmgi <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- sim/backplane_bus_module_interface_tb.sv
// Bench for the backplane bus module with a processor model opposite.
// Assumes short line-clock periods so both rates are measured quickly.
`timescale 1ns/1ps
`default_nettype none
module backplane_bus_module_interface_tb;
   import bus_module_pkg::*;
   localparam int P60 = 20;
   localparam int P50 = 24;
   localparam logic [15:0] VEC = 16'h0154;
   logic clk, rstn, dma_req, dma_done, irq_req, halt_req, ltc_en, l50;
   logic rply, sack, dmr, halt, evnt, dal_oe, dmgo_l, iako_l, refresh, pwr_ok, binit, master;
   logic [3:0] irq;
   logic [DATA_W-1:0] dal_l, rd;
   logic [DAL_W-1:0] pin_dal;
   bus_in_t b;
   int errors, n_tests, n_ref, n;
   bit ok, passed;
   bus_module #(.VECTOR(VEC), .IRQ_LEVEL(LVL_MIN), .LTC60_PERIOD(P60),
         .LTC50_PERIOD(P50)) DUT (
      .SYS_CLK_IN(clk), .RSTN_IN(rstn),
      .BSYNC_L_IN(~b.sync), .BDIN_L_IN(~b.din), .BDOUT_L_IN(~b.dout), .BWTBT_L_IN(~b.wtbt),
      .BBS7_L_IN(~b.bs7), .BREF_L_IN(~b.refr), .BINIT_L_IN(~b.init), .BIAKI_L_IN(~b.iaki),
      .BDMGI_L_IN(~b.dmgi), .BDCOK_H_IN(b.dcok), .BPOK_H_IN(b.pok),
      .BDAL_L_IN(pin_dal), .BDAL_L_OUT(dal_l), .BDAL_OE_OUT(dal_oe),
      .BRPLY_OE_OUT(rply), .BDMR_OE_OUT(dmr), .BSACK_OE_OUT(sack), .BHALT_OE_OUT(halt),
      .BEVNT_OE_OUT(evnt), .BIRQ_OE_OUT(irq), .BDMGO_L_OUT(dmgo_l), .BIAKO_L_OUT(iako_l),
      .DMA_REQ_IN(dma_req), .DMA_DONE_IN(dma_done), .IRQ_REQ_IN(irq_req),
      .HALT_REQ_IN(halt_req), .LTC_EN_IN(ltc_en), .LINE_50HZ_IN(l50),
      .DMA_MASTER_OUT(master), .REFRESH_OUT(refresh), .POWER_OK_OUT(pwr_ok),
      .BUS_INIT_OUT(binit));
   bus_host_model host (.clk_in(clk), .rply_in(rply), .sack_in(sack), .iako_l_in(iako_l),
      .dmgo_l_in(dmgo_l), .dal_oe_in(dal_oe), .dal_l_in(dal_l), .b_out(b),
      .pin_dal_out(pin_dal));
   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Refresh pulses are one cycle wide, so count them here
   always @(posedge clk) if (refresh === 1'b1) n_ref <= n_ref + 1;
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Address of a word in our slot of the I/O page
   function automatic logic [DAL_W-1:0] adr(input logic [1:0] idx, input bit hi);
      return {9'h1FF, DEF_BASE[12:3], idx, hi};
   endfunction
   // Word and byte writes; junk in the unselected byte must not land
   task automatic t_word();
      host.xfer(1, 1, 0, 0, adr(2'd1, 0), 16'hA55A, rd, ok);
      check("write reply", ok, 1);
      host.xfer(0, 1, 0, 0, adr(2'd1, 0), '0, rd, ok);
      check("read reply", ok, 1);
      check("read data", rd, 16'hA55A);
      host.xfer(1, 1, 0, 1, adr(2'd1, 1), 16'h7E00, rd, ok);
      host.xfer(1, 1, 0, 1, adr(2'd1, 0), 16'hFF3C, rd, ok);
      host.xfer(0, 1, 0, 0, adr(2'd1, 0), '0, rd, ok);
      check("byte merge", rd, 16'h7E3C);
   endtask
   // Cycles that must go unanswered, then an answered read showing the word was kept
   task automatic t_miss();
      host.xfer(0, 0, 0, 0, adr(2'd1, 0), '0, rd, ok);
      check("no bank7", ok, 0);
      host.xfer(1, 1, 0, 0, adr(2'd1, 0) ^ 22'h8, 16'h1111, rd, ok);
      check("other slot", ok, 0);
      host.xfer(0, 1, 1, 0, adr(2'd1, 0), '0, rd, ok);
      check("refresh reply", ok, 0);
      check("refresh pulse", n_ref, 1);
      host.xfer(0, 1, 0, 0, adr(2'd1, 0), '0, rd, ok);
      check("data kept", rd, 16'h7E3C);
   endtask
   task automatic t_irq();
      logic [DATA_W-1:0] v;
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      repeat (2) @(posedge clk);
      check("irq level", irq, 4'b0001);
      host.iack(v, ok, passed);
      check("vector reply", ok, 1);
      check("vector", v, VEC);
      check("ack blocked", passed, 0);
      check("irq cleared", irq, 4'b0000);
      host.iack(v, ok, passed);
      check("idle no reply", ok, 0);
      check("ack passed", passed, 1);
   endtask
   task automatic t_dma();
      dma_req <= 1'b1;
      @(posedge clk);
      dma_req <= 1'b0;
      repeat (2) @(posedge clk);
      check("dma request", dmr, 1);
      host.grant(ok, passed);
      check("grant ack", ok, 1);
      check("grant held", passed, 0);
      check("request dropped", dmr, 0);
      check("master", master, 1);
      dma_done <= 1'b1;
      @(posedge clk);
      dma_done <= 1'b0;
      repeat (2) @(posedge clk);
      check("released", {master, sack}, 2'b00);
      host.grant(ok, passed);
      check("idle no ack", ok, 0);
      check("grant passed", passed, 1);
   endtask
   // Initialize arrives while a request and an interrupt are pending
   task automatic t_init();
      irq_req <= 1'b1;
      dma_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      dma_req <= 1'b0;
      host.b.init <= 1'b1;
      repeat (4) @(posedge clk);
      check("init seen", binit, 1);
      check("init cleared", {irq, dmr}, 5'b0);
      host.b.init <= 1'b0;
      repeat (4) @(posedge clk);
      check("init over", {binit, irq, dmr}, 6'b0);
   endtask
   task automatic t_power();
      check("power ok", pwr_ok, 1);
      host.b.pok <= 1'b0;
      repeat (4) @(posedge clk);
      check("ac fail", pwr_ok, 0);
      host.b.pok <= 1'b1;
      halt_req <= 1'b1;
      repeat (4) @(posedge clk);
      check("power back", pwr_ok, 1);
      check("halt", halt, 1);
      halt_req <= 1'b0;
      repeat (2) @(posedge clk);
      check("halt off", halt, 0);
      dma_req <= 1'b1;
      @(posedge clk);
      dma_req <= 1'b0;
      host.b.dcok <= 1'b0;
      repeat (4) @(posedge clk);
      check("dc fail", {pwr_ok, dmr}, 2'b00);
      host.b.dcok <= 1'b1;
      repeat (4) @(posedge clk);
      check("dc back", pwr_ok, 1);
   endtask
   // High span and period of the event line at one rate
   task automatic t_ltc(input bit sel, input int per);
      int hi, tot;
      l50 <= sel;
      ltc_en <= 1'b1;
      for (n = 0; n < 3 * per && evnt !== 1'b1; n++) @(posedge clk);
      for (hi = 0; hi < per && evnt === 1'b1; hi++) @(posedge clk);
      for (tot = hi; tot < 2 * per && evnt !== 1'b1; tot++) @(posedge clk);
      check("ltc high", hi, per / 2);
      check("ltc period", tot, per);
      ltc_en <= 1'b0;
      repeat (2) @(posedge clk);
      check("ltc off", evnt, 0);
   endtask
   initial begin
      errors = 0;
      n_tests = 0;
      n_ref = 0;
      rstn = 1'b0;
      dma_req = 1'b0;
      dma_done = 1'b0;
      irq_req = 1'b0;
      halt_req = 1'b0;
      ltc_en = 1'b0;
      l50 = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      t_word();
      t_miss();
      t_irq();
      t_dma();
      t_init();
      t_power();
      t_ltc(1'b0, P60);
      t_ltc(1'b1, P50);
      conclude();
   end
   // Watchdog, far beyond the few hundred cycles the run takes
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
